// ==== logic/sarsq_ctrl.sv ====
// successive-approximation converter sequencer, flags and register file
`timescale 1ns/1ps
module sarsq_ctrl (
  input wire logic CLK,
  input wire logic RESETN,
  input wire sarsq_pkg::sarsq_bus_t BUS,
  output logic [31:0] RDATA,
  input wire logic [2:0] TIMER_WAVE,
  input wire logic EXT_TRIGGER,
  input wire logic [sarsq_pkg::DW-1:0] CELL_RESULT,
  output logic CELL_POWER,
  output logic CELL_SAMPLE,
  output logic CELL_CONVERT,
  output logic [1:0] CELL_CHANNEL,
  output logic CONV_CLK_TICK,
  output sarsq_pkg::sarsq_dma_t DMA,
  output logic IRQ
);
  import sarsq_pkg::*;

  logic soft_rst;
  logic [31:0] mode_reg;
  logic [NCH-1:0] chen_reg;
  logic [NCH-1:0] eoc_reg;
  logic [NCH-1:0] ovr_reg;
  logic data_ready_flag_reg;
  logic govr_reg;
  logic [31:0] imask_reg;
  logic [DW-1:0] last_reg;
  logic [1:0] last_ch_reg;
  logic [DW-1:0] res_reg [NCH];
  logic [6:0] div_reg;
  logic tick;
  logic [2:0] hw_sync1_reg;
  logic [2:0] hw_sync2_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic trig_prev_reg;
  logic trig_sel;
  logic hw_start;
  logic sw_start;
  logic start_req;
  sarsq_state_t state_reg;
  logic [8:0] cnt_reg;
  logic [1:0] ch_reg;
  logic done;
  logic low_resolution_select;
  logic [31:0] status;
  logic [DW-1:0] done_data;
  logic [31:0] rdata_next;
  logic data_ready_flag_prev_reg;

  assign low_resolution_select = mode_reg[MODE_LOW_RESOLUTION_SELECT_BIT];
  assign soft_rst = BUS.wr && BUS.addr == OFF_CTRL && BUS.wdata[CTRL_RST_BIT];
  assign sw_start = BUS.wr && BUS.addr == OFF_CTRL && BUS.wdata[CTRL_START_BIT];

  // conversion clock enable: one pulse per (div+1)*2 master cycles
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_reg <= 7'h00;
      tick <= 1'b0;
    end else if (soft_rst) begin
      div_reg <= 7'h00;
      tick <= 1'b0;
    end else begin
      if (div_reg >= {mode_reg[MODE_DIV_LSB +: 6], 1'b1}) begin
        div_reg <= 7'h00;
        tick <= 1'b1;
      end else begin
        div_reg <= div_reg + 7'h01;
        tick <= 1'b0;
      end
    end
  end

  // hardware trigger synchronisers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hw_sync1_reg <= 3'h0;
      hw_sync2_reg <= 3'h0;
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      hw_sync1_reg <= TIMER_WAVE;
      hw_sync2_reg <= hw_sync1_reg;
      ext_sync1_reg <= EXT_TRIGGER;
      ext_sync2_reg <= ext_sync1_reg;
      trig_prev_reg <= trig_sel;
    end
  end

  always_comb begin
    unique case (mode_reg[MODE_TRGSRC_LSB +: 3])
      TRG_TMR0: trig_sel = hw_sync2_reg[0];
      TRG_TMR1: trig_sel = hw_sync2_reg[1];
      TRG_TMR2: trig_sel = hw_sync2_reg[2];
      TRG_EXT: trig_sel = ext_sync2_reg;
      default: trig_sel = 1'b0;
    endcase
  end

  assign hw_start = mode_reg[MODE_HW_TRIGGER_ENABLE_BIT] && trig_sel && !trig_prev_reg;
  assign start_req = sw_start || hw_start;

  // sequencer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= S_IDLE;
      cnt_reg <= 9'h000;
      ch_reg <= 2'h0;
    end else if (soft_rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 9'h000;
      ch_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          // starts while busy never reach here
          if (start_req && chen_reg != '0) begin
            ch_reg <= 2'h0;
            if (mode_reg[MODE_SLEEP_BIT]) begin
              state_reg <= S_STARTUP;
              // widened before the shift so a field of 31 still gives 256 ticks
              cnt_reg <= (9'(mode_reg[MODE_START_LSB +: 5]) + 9'h001) << START_MULT_SHIFT;
            end else begin
              state_reg <= S_NEXT;
            end
          end
        end
        S_STARTUP: begin
          if (tick) begin
            if (cnt_reg == 9'h001) begin
              state_reg <= S_NEXT;
            end else begin
              cnt_reg <= cnt_reg - 9'h001;
            end
          end
        end
        S_NEXT: begin
          if (chen_reg[ch_reg]) begin
            state_reg <= S_SAMPLE;
            cnt_reg <= 9'(mode_reg[MODE_SH_LSB +: 4]) + 9'h001;
          end else if (ch_reg == 2'(NCH - 1)) begin
            state_reg <= S_IDLE;
          end else begin
            ch_reg <= ch_reg + 2'h1;
          end
        end
        S_SAMPLE: begin
          if (tick) begin
            if (cnt_reg == 9'h001) begin
              state_reg <= S_CONVERT;
              cnt_reg <= 9'(CONV_CYCLES);
            end else begin
              cnt_reg <= cnt_reg - 9'h001;
            end
          end
        end
        S_CONVERT: begin
          if (tick) begin
            if (cnt_reg == 9'h001) begin
              if (ch_reg == 2'(NCH - 1)) begin
                state_reg <= S_IDLE;
              end else begin
                ch_reg <= ch_reg + 2'h1;
                state_reg <= S_NEXT;
              end
            end else begin
              cnt_reg <= cnt_reg - 9'h001;
            end
          end
        end
      endcase
    end
  end

  assign done = state_reg == S_CONVERT && tick && cnt_reg == 9'h001;
  assign done_data = low_resolution_select ? (CELL_RESULT & LOW_RESOLUTION_SELECT_MASK) : CELL_RESULT;

  // mode, channel enable and interrupt mask registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_reg <= 32'h00000000;
      chen_reg <= '0;
      imask_reg <= 32'h00000000;
    end else if (soft_rst) begin
      mode_reg <= 32'h00000000;
      chen_reg <= '0;
      imask_reg <= 32'h00000000;
    end else if (BUS.wr) begin
      if (BUS.addr == OFF_MODE) begin
        mode_reg <= BUS.wdata & MODE_MASK;
      end
      if (BUS.addr == OFF_CHSET) begin
        chen_reg <= chen_reg | BUS.wdata[NCH-1:0];
      end
      if (BUS.addr == OFF_CHCLR) begin
        chen_reg <= chen_reg & ~BUS.wdata[NCH-1:0];
      end
      if (BUS.addr == OFF_IRQSET) begin
        imask_reg <= imask_reg | (BUS.wdata & IRQ_MASK_BITS);
      end
      if (BUS.addr == OFF_IRQCLR) begin
        imask_reg <= imask_reg & ~BUS.wdata;
      end
    end
  end

  // results and flags; a new completion wins over a read clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      eoc_reg <= '0;
      ovr_reg <= '0;
      data_ready_flag_reg <= 1'b0;
      govr_reg <= 1'b0;
      last_reg <= '0;
      last_ch_reg <= 2'h0;
      for (int i = 0; i < NCH; i++) begin
        res_reg[i] <= '0;
      end
    end else if (soft_rst) begin
      eoc_reg <= '0;
      ovr_reg <= '0;
      data_ready_flag_reg <= 1'b0;
      govr_reg <= 1'b0;
      last_reg <= '0;
      last_ch_reg <= 2'h0;
      for (int i = 0; i < NCH; i++) begin
        res_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (BUS.rd && BUS.addr == OFF_CH0 + 8'(4 * i)) begin
          eoc_reg[i] <= 1'b0;
        end
      end
      if (BUS.rd && BUS.addr == OFF_LAST) begin
        data_ready_flag_reg <= 1'b0;
        eoc_reg[last_ch_reg] <= 1'b0;
      end
      if (BUS.rd && BUS.addr == OFF_STATUS) begin
        ovr_reg <= '0;
        govr_reg <= 1'b0;
      end
      if (done) begin
        res_reg[ch_reg] <= done_data;
        last_reg <= done_data;
        last_ch_reg <= ch_reg;
        eoc_reg[ch_reg] <= 1'b1;
        data_ready_flag_reg <= 1'b1;
        if (eoc_reg[ch_reg]) begin
          ovr_reg[ch_reg] <= 1'b1;
        end
        if (data_ready_flag_reg) begin
          govr_reg <= 1'b1;
        end
      end
    end
  end

  assign status = {14'h0003, govr_reg, data_ready_flag_reg, 4'h0, ovr_reg, 4'h0, eoc_reg};

  always_comb begin
    rdata_next = 32'h00000000;
    unique case (BUS.addr)
      OFF_MODE: rdata_next = mode_reg;
      OFF_CHSTAT: rdata_next = {28'h0000000, chen_reg};
      OFF_STATUS: rdata_next = status;
      OFF_LAST: rdata_next = {22'h000000, last_reg};
      OFF_IRQMASK: rdata_next = imask_reg;
      OFF_CH0: rdata_next = {22'h000000, res_reg[0]};
      OFF_CH1: rdata_next = {22'h000000, res_reg[1]};
      OFF_CH2: rdata_next = {22'h000000, res_reg[2]};
      OFF_CH3: rdata_next = {22'h000000, res_reg[3]};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // outputs, all registered
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 32'h00000000;
      CELL_POWER <= 1'b0;
      CELL_SAMPLE <= 1'b0;
      CELL_CONVERT <= 1'b0;
      CELL_CHANNEL <= 2'h0;
      CONV_CLK_TICK <= 1'b0;
      DMA <= '0;
      IRQ <= 1'b0;
      data_ready_flag_prev_reg <= 1'b0;
    end else if (soft_rst) begin
      // the cell powers down and pending requests drop, as after a hardware reset
      RDATA <= 32'h00000000;
      CELL_POWER <= 1'b0;
      CELL_SAMPLE <= 1'b0;
      CELL_CONVERT <= 1'b0;
      CELL_CHANNEL <= 2'h0;
      CONV_CLK_TICK <= 1'b0;
      DMA <= '0;
      IRQ <= 1'b0;
      data_ready_flag_prev_reg <= 1'b0;
    end else begin
      RDATA <= BUS.rd ? rdata_next : 32'h00000000;
      // normal mode keeps the cell powered once the first sequence has started
      CELL_POWER <= mode_reg[MODE_SLEEP_BIT] ? (state_reg != S_IDLE) :
                    (CELL_POWER || state_reg != S_IDLE);
      CELL_SAMPLE <= state_reg == S_SAMPLE;
      CELL_CONVERT <= state_reg == S_CONVERT;
      CELL_CHANNEL <= ch_reg;
      CONV_CLK_TICK <= tick;
      data_ready_flag_prev_reg <= data_ready_flag_reg;
      DMA.req <= data_ready_flag_reg && !data_ready_flag_prev_reg && chen_reg[last_ch_reg];
      DMA.wide <= !low_resolution_select;
      DMA.data <= last_reg;
      IRQ <= |(status & imask_reg);
    end
  end
endmodule : sarsq_ctrl

// ==== logic/sarsq_pkg.sv ====
// constants and types shared by the converter controller
package sarsq_pkg;
  localparam int NCH = 4;
  localparam int DW = 10;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CHSET = 8'h10;
  localparam logic [7:0] OFF_CHCLR = 8'h14;
  localparam logic [7:0] OFF_CHSTAT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_LAST = 8'h20;
  localparam logic [7:0] OFF_IRQSET = 8'h24;
  localparam logic [7:0] OFF_IRQCLR = 8'h28;
  localparam logic [7:0] OFF_IRQMASK = 8'h2c;
  localparam logic [7:0] OFF_CH0 = 8'h30;
  localparam logic [7:0] OFF_CH1 = 8'h34;
  localparam logic [7:0] OFF_CH2 = 8'h38;
  localparam logic [7:0] OFF_CH3 = 8'h3c;
  localparam int CTRL_RST_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int MODE_HW_TRIGGER_ENABLE_BIT = 0;
  localparam int MODE_TRGSRC_LSB = 1;
  localparam int MODE_LOW_RESOLUTION_SELECT_BIT = 4;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int MODE_DIV_LSB = 8;
  localparam int MODE_START_LSB = 16;
  localparam int MODE_SH_LSB = 24;
  localparam logic [31:0] MODE_MASK = 32'h0f1f3f3f;
  localparam int ST_OVR_LSB = 8;
  localparam int ST_DATA_READY_FLAG_BIT = 16;
  localparam int ST_GOVR_BIT = 17;
  localparam logic [31:0] STATUS_RESET = 32'h000c0000;
  localparam logic [31:0] IRQ_MASK_BITS = 32'h00030f0f;
  localparam logic [2:0] TRG_TMR0 = 3'h0;
  localparam logic [2:0] TRG_TMR1 = 3'h1;
  localparam logic [2:0] TRG_TMR2 = 3'h2;
  localparam logic [2:0] TRG_EXT = 3'h6;
  localparam logic [3:0] CONV_CYCLES = 4'ha;
  localparam int START_MULT_SHIFT = 3;
  localparam logic [DW-1:0] LOW_RESOLUTION_SELECT_MASK = 10'h0ff;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sarsq_bus_t;

  typedef struct packed {
    logic req;
    logic wide;
    logic [DW-1:0] data;
  } sarsq_dma_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_STARTUP = 5'h02,
    S_SAMPLE = 5'h04,
    S_CONVERT = 5'h08,
    S_NEXT = 5'h10
  } sarsq_state_t;
endpackage : sarsq_pkg

// ==== testbench/sarsq_cell_model.sv ====
// behavioural analog cell: each result encodes the channel it sampled
`timescale 1ns/1ps
module sarsq_cell_model (
  input wire logic CLK,
  input wire logic POWER,
  input wire logic [1:0] CHANNEL,
  output logic [9:0] RESULT
);
  initial begin
    RESULT = 10'h155;
  end
  // an unpowered cell has no valid output, so it toggles instead of holding
  always @(posedge CLK) begin
    RESULT <= POWER ? {8'he9, CHANNEL} : ~RESULT;
  end
endmodule : sarsq_cell_model

// ==== testbench/sarsq_ctrl_chk.sv ====
// port-level checks on the converter controller
`timescale 1ns/1ps
module sarsq_ctrl_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CELL_POWER,
  input wire logic CELL_SAMPLE,
  input wire logic CELL_CONVERT,
  input wire logic [1:0] CELL_CHANNEL,
  input wire logic CONV_CLK_TICK,
  input wire sarsq_pkg::sarsq_dma_t DMA
);
  import sarsq_pkg::*;
  logic [3:0] idle_cnt;
  logic [3:0] conv_ticks;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // cycles since the conversion phase ended, saturating
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_cnt <= 4'hf;
    end else if (CELL_CONVERT) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hf) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end
  // conversion clock ticks seen while the conversion phase stands
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      conv_ticks <= 4'h0;
    end else if (!CELL_CONVERT) begin
      conv_ticks <= 4'h0;
    end else if (CONV_CLK_TICK) begin
      conv_ticks <= conv_ticks + 4'h1;
    end
  end
  sequence s_conv_hold;
    CELL_CONVERT [*8];
  endsequence
  conv_hold_a: assert property ($rose(CELL_CONVERT) |-> s_conv_hold)
    else $error("conversion phase too short");
  conv_ticks_a: assert property ($fell(CELL_CONVERT) |-> conv_ticks == CONV_CYCLES)
    else $error("conversion phase not ten clock ticks");
  sample_first_a: assert property ($rose(CELL_CONVERT) |-> $past(CELL_SAMPLE))
    else $error("conversion without sample phase");
  phase_excl_a: assert property (!(CELL_SAMPLE && CELL_CONVERT))
    else $error("sample and convert together");
  tick_gap_a: assert property (CONV_CLK_TICK |=> !CONV_CLK_TICK)
    else $error("conversion clock faster than half master");
  dma_pulse_a: assert property (DMA.req |=> !DMA.req)
    else $error("transfer request longer than one cycle");
  dma_narrow_a: assert property (DMA.req && !DMA.wide |-> DMA.data[9:8] == 2'b00)
    else $error("narrow transfer carries upper bits");
  dma_after_a: assert property (DMA.req |-> idle_cnt <= 4'h4)
    else $error("transfer request without a finished conversion");
  chan_stable_a: assert property (CELL_CONVERT && $past(CELL_CONVERT) |-> $stable(CELL_CHANNEL))
    else $error("channel changed during conversion");
  cell_powered_a: assert property (CELL_SAMPLE || CELL_CONVERT |-> CELL_POWER)
    else $error("cell used while powered down");
endmodule : sarsq_ctrl_chk

bind sarsq_ctrl sarsq_ctrl_chk u_chk (.CLK(CLK), .RESETN(RESETN), .CELL_POWER(CELL_POWER),
  .CELL_SAMPLE(CELL_SAMPLE), .CELL_CONVERT(CELL_CONVERT), .CELL_CHANNEL(CELL_CHANNEL),
  .CONV_CLK_TICK(CONV_CLK_TICK), .DMA(DMA));

// ==== testbench/sarsq_ctrl_tb.sv ====
// self-checking bench for the converter controller
`timescale 1ns/1ps
module sarsq_ctrl_tb;
  import sarsq_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  sarsq_bus_t bus = '0;
  logic [31:0] rdata;
  logic [3:0] trg = 4'h0;
  logic [DW-1:0] cres;
  logic pwr, smp, cnv, cnv_q, tick, irq, dma_wide;
  logic [1:0] chan;
  sarsq_dma_t dma;
  int fail_count = 0;
  int total_checks = 0;
  int conv_count = 0;
  int dma_count = 0;
  int cycles = 0;
  logic [2:0] codes[4] = '{TRG_TMR0, TRG_TMR1, TRG_TMR2, TRG_EXT};
  logic [3:0] hot[4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  sarsq_ctrl u_sarsq_ctrl (.CLK(CLK), .RESETN(RESETN), .BUS(bus), .RDATA(rdata),
    .TIMER_WAVE(trg[2:0]), .EXT_TRIGGER(trg[3]), .CELL_RESULT(cres), .CELL_POWER(pwr),
    .CELL_SAMPLE(smp), .CELL_CONVERT(cnv), .CELL_CHANNEL(chan), .CONV_CLK_TICK(tick),
    .DMA(dma), .IRQ(irq));
  sarsq_cell_model u_sarsq_cell_model (.CLK(CLK), .POWER(pwr), .CHANNEL(chan), .RESULT(cres));
  initial begin
    forever #5 CLK = ~CLK;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    cnv_q <= cnv;
    if (cnv === 1'b1 && cnv_q !== 1'b1) conv_count++;
    if (dma.req === 1'b1) begin
      dma_count++;
      dma_wide = dma.wide;
    end
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLK);
    bus <= '0;
    @(posedge CLK);
  endtask : bus_wr
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge CLK);
    bus <= '0;
    #1 chk($sformatf("register %h", a), e, rdata);
    @(posedge CLK);
  endtask : reg_chk
  task automatic reset_regs;
    logic [7:0] ra[7];
    ra = '{OFF_MODE, OFF_CHSTAT, OFF_STATUS, OFF_LAST, OFF_IRQMASK, OFF_CH0, 8'h40};
    foreach (ra[i]) reg_chk(ra[i], ra[i] == OFF_STATUS ? STATUS_RESET : 32'h0);
  endtask : reset_regs
  // waits until n more conversions have finished
  task automatic run(input int n);
    int t0;
    t0 = conv_count;
    for (int i = 0; i < 3000 && !(conv_count == t0 + n && cnv === 1'b0); i++) @(posedge CLK);
    repeat (4) @(posedge CLK);
  endtask : run
  initial begin
    int c;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    reset_regs();
    bus_wr(OFF_CHSET, 32'hf);
    bus_wr(OFF_CHCLR, 32'ha);
    reg_chk(OFF_CHSTAT, 32'h5);
    bus_wr(OFF_CTRL, 32'h0);
    bus_wr(OFF_MODE, 32'hffffffff);
    reg_chk(OFF_MODE, MODE_MASK);
    bus_wr(OFF_MODE, 32'h01000000);
    chk("conversions", 32'h0, 32'(conv_count));
    bus_wr(OFF_CTRL, 32'h2);
    bus_wr(OFF_CTRL, 32'h2);
    run(2);
    chk("conversions", 32'h2, 32'(conv_count));
    reg_chk(OFF_STATUS, 32'h000f0005);
    reg_chk(OFF_STATUS, 32'h000d0005);
    chk("dma count", 32'h1, 32'(dma_count));
    chk("dma wide", 32'h1, {31'h0, dma_wide});
    bus_wr(OFF_CTRL, 32'h2);
    run(2);
    reg_chk(OFF_STATUS, 32'h000f0505);
    reg_chk(OFF_CH0, 32'h3a4);
    reg_chk(OFF_STATUS, 32'h000d0004);
    reg_chk(OFF_LAST, 32'h3a6);
    reg_chk(OFF_STATUS, STATUS_RESET);
    bus_wr(OFF_MODE, 32'h01000010);
    bus_wr(OFF_CTRL, 32'h2);
    run(2);
    reg_chk(OFF_CH2, 32'h0a6);
    reg_chk(OFF_LAST, 32'h0a6);
    chk("dma count", 32'h2, 32'(dma_count));
    chk("dma wide", 32'h0, {31'h0, dma_wide});
    foreach (codes[i]) begin
      bus_wr(OFF_MODE, {8'h01, 20'h0, codes[i], 1'b1});
      c = conv_count;
      trg <= ~hot[i];
      repeat (40) @(posedge CLK);
      trg <= 4'h0;
      @(posedge CLK);
      trg <= hot[i];
      run(2);
      chk("hw trigger", 32'(c + 2), 32'(conv_count));
    end
    bus_wr(OFF_CTRL, 32'h2);
    run(2);
    chk("sw with hw", 32'(c + 4), 32'(conv_count));
    trg <= 4'h0;
    chk("power", 32'h1, {31'h0, pwr});
    bus_wr(OFF_MODE, 32'h01000200);
    repeat (8) @(posedge CLK);
    @(posedge tick);
    c = 0;
    do begin
      @(posedge CLK);
      #1 c++;
    end while (tick !== 1'b1);
    @(posedge CLK);
    chk("tick period", 32'h6, 32'(c));
    bus_wr(OFF_MODE, 32'h01000020);
    bus_wr(OFF_CTRL, 32'h2);
    run(2);
    chk("power", 32'h0, {31'h0, pwr});
    bus_wr(OFF_IRQSET, 32'h00010000);
    reg_chk(OFF_IRQMASK, 32'h00010000);
    chk("irq", 32'h1, {31'h0, irq});
    bus_wr(OFF_IRQCLR, 32'h00010000);
    reg_chk(OFF_IRQMASK, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    bus_wr(OFF_IRQSET, 32'h00000001);
    reg_chk(OFF_IRQMASK, 32'h00000001);
    chk("irq", 32'h1, {31'h0, irq});
    bus_wr(OFF_MODE, 32'h01000000);
    bus_wr(OFF_CTRL, 32'h2);
    run(2);
    chk("power", 32'h1, {31'h0, pwr});
    bus_wr(OFF_CTRL, 32'h1);
    reset_regs();
    chk("power", 32'h0, {31'h0, pwr});
    chk("irq", 32'h0, {31'h0, irq});
    tally_and_finish();
  end
endmodule : sarsq_ctrl_tb
